// ---- bench/spp_board_model.sv ----
// board side of the pins: resolves each pin level
// assumes ext_i is where an undriven, unpulled pin floats
`default_nettype none
module spp_board_model (
  input  wire spp_pkg::spp_pad_type          pad_i,
  input  wire logic [spp_pkg::PIN_COUNT-1:0] ext_i,
  output var  logic [spp_pkg::PIN_COUNT-1:0] lvl_o
);
  import spp_pkg::*;
  // drive wins, then pulls, else the floating level
  always_comb begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      lvl_o[n] = pad_i.oe[n] ? pad_i.out[n] : pad_i.pull_up[n] | (~pad_i.pull_down[n] & ext_i[n]);
    end
  end
endmodule
`default_nettype wire

// ---- bench/spp_port_properties.sv ----
// port-level checker for the six pin port block
// assumes bind onto spp_port and one clock domain
`default_nettype none
module spp_port_properties (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire spp_pkg::spp_wb_req_type       wb_req_i,
  input wire spp_pkg::spp_wb_rsp_type       wb_rsp_o,
  input wire logic [spp_pkg::PIN_COUNT-1:0] pad_in_i,
  input wire logic                          pwm_i,
  input wire spp_pkg::spp_pad_type          pad_o,
  input wire logic [spp_pkg::PIN_COUNT-1:0] adc_sel_o,
  input wire logic                          pwm_sel_o
);
  import spp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers exactly one cycle after a fresh request
  ack_after_req_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property (!(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack)
    else $error("ack without request");
  rd_upper_zero_a: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  // pads, ack and converter selects quiet right after reset
  reset_quiet_a: assert property ($fell(rst_i) |-> pad_o == '0 && !wb_rsp_o.ack && adc_sel_o == '0)
    else $error("outputs not quiet after reset");
  // a pin never drives and pulls at once, nor pulls both ways
  drive_no_pull_a: assert property ((pad_o.oe & (pad_o.pull_up | pad_o.pull_down)) == '0)
    else $error("pad drives while pulled");
  pull_exclusive_a: assert property ((pad_o.pull_up & pad_o.pull_down) == '0)
    else $error("both pulls on");
  conv_release_a: assert property ((adc_sel_o & pad_o.oe) == '0)
    else $error("converter pin driven");
  pwm_not_conv_a: assert property (pwm_sel_o |-> !adc_sel_o[4])
    else $error("pin 4 given to both units");
  // pwm level reaches pin 4 one cycle later, in any drive style, whenever pin 4 is driven
  pwm_follow_a: assert property (pwm_sel_o && $past(pwm_sel_o) && pad_o.oe[4] |-> pad_o.out[4] == $past(pwm_i))
    else $error("pwm level not on pin 4");
  cover property (wb_rsp_o.ack && wb_req_i.we);
  cover property (pwm_sel_o && pad_o.oe[4]);
  cover property (adc_sel_o != '0);
endmodule
bind spp_port spp_port_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pad_in_i(pad_in_i),
  .pwm_i(pwm_i), .pad_o(pad_o), .adc_sel_o(adc_sel_o), .pwm_sel_o(pwm_sel_o));
`default_nettype wire

// ---- bench/spp_port_tb_top.sv ----
// self-checking bench for the six pin port block
// assumes the board model on the pins, random pwm level
`default_nettype none
module spp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spp_pkg::*;
  logic           clk_i = 1'b0;
  logic           rst_i = 1'b1;
  logic           pwm_i = 1'b0;
  spp_wb_req_type wb_req_i = '0;
  spp_wb_rsp_type wb_rsp_o;
  spp_pad_type    pad_o;
  logic [5:0]     adc_sel_o, pad_in_i, ext = '0;
  logic           pwm_sel_o;
  int             miscompares = 0, compares = 0, seed = 32'h9fadaaf2;
  logic [31:0]    rd;
  always #5 clk_i = ~clk_i;
  spp_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pad_in_i(pad_in_i),
    .pwm_i(pwm_i), .pad_o(pad_o), .adc_sel_o(adc_sel_o), .pwm_sel_o(pwm_sel_o));
  spp_board_model u_board (.pad_i(pad_o), .ext_i(ext), .lvl_o(pad_in_i));
  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic fail(string m);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic cmp_reg(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("reg %h exp %h", got, exp));
  endtask
  task automatic cmp_pin(logic [30:0] got, logic [30:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("pins %h exp %h", got, exp));
  endtask
  // one classic cycle; waits for ack, bounded
  task automatic wb(logic we, logic [15:0] idx, logic [1:0] sel, logic [15:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: {2'b00, sel}, dat: {16'h0, d}};
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1 && ++t < 20);
    if (t >= 20) begin
      fail("no ack");
      tally_and_finish();
    end else begin
      rd = wb_rsp_o.dat;
      wb_req_i <= '0;
    end
  endtask
  // pad controls from the settings: {oe, out&oe, pull up, pull down, adc, pwm}
  function automatic logic [30:0] exp_pins(logic [7:0] dir, dl, dh, fl, fh, dat, logic pw);
    logic [5:0] oe, out, pu, pd, adc;
    logic [1:0] s, f;
    logic       lv;
    {oe, out, pu, pd, adc} = '0;
    for (int n = 0; n < 6; n++) begin
      s = {dh[n], dl[n]};
      f = {fh[n], fl[n]};
      adc[n] = (f == FN_ADC);
      lv = (f == FN_GPIO) ? dat[n] : (n == 4 && f == FN_PWM) ? pw : 1'b0;
      if (dir[n]) begin
        pu[n] = (s == IN_PULL_UP);
        pd[n] = (s == IN_PULL_DOWN);
      end else if (f != FN_ADC) begin
        oe[n] = s == DRV_CMOS || (s == DRV_PCH && lv) || (s == DRV_NCH && !lv);
        out[n] = (s == DRV_CMOS) ? lv : (s == DRV_PCH);
      end
    end
    return {oe, out & oe, pu, pd, adc, fh[4] && !fl[4]};
  endfunction
  initial begin
    logic [7:0]  dir, dl, dh, fl, fh, dat;
    logic [31:0] a, b;
    logic [30:0] e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 16'hf21e, 2'b11, 16'hffff);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, IDX_DATA + 16'(i), 2'b01, 16'h0);
      cmp_reg(rd, 32'h0);
    end
    cmp_pin({pad_o.oe, pad_o.out & pad_o.oe, pad_o.pull_up, pad_o.pull_down, adc_sel_o, pwm_sel_o}, '0);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      a = $random(seed);
      b = $random(seed);
      {fl, dh, dl, dir} = a;
      {fh, dat} = b[15:0];
      if (i < 2) begin // legal function codes only in these corner cases
        {dir, dl, dh, fl, fh} = {8'h00, 8'hff, 8'hff, 8'h00, 3'b000, i[0], 4'h0};
      end
      ext <= b[21:16];
      pwm_i <= b[22];
      wb(1'b1, IDX_DIR, 2'b01, {8'h0, dir});
      wb(1'b1, IDX_DRV_LO, 2'b11, {dh, dl});
      wb(1'b1, IDX_FN_LO, 2'b11, {fh, fl});
      wb(1'b1, IDX_DATA, 2'b01, {8'h0, dat});
      wb(1'b0, IDX_DRV_HI, 2'b01, 16'h0);
      cmp_reg(rd, {24'h0, dh});
      wb(1'b0, IDX_FN_LO, 2'b11, 16'h0);
      cmp_reg(rd, {16'h0, fh, fl});
      e = exp_pins(dir, dl, dh, fl, fh, dat, pwm_i);
      cmp_pin({pad_o.oe, pad_o.out & pad_o.oe, pad_o.pull_up, pad_o.pull_down, adc_sel_o, pwm_sel_o}, e);
      wb(1'b0, IDX_DATA, 2'b01, 16'h0);
      cmp_reg(rd, {24'h0, dat[7:6], ((e[18:13] | (~e[12:7] & ext)) & dir[5:0]) | (dat[5:0] & ~dir[5:0])});
      $display("test %0d done", i);
    end
    // second reset in mid-run: drive, function and direction settings must fall back to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_DRV_LO, 2'b11, 16'h0);
    cmp_reg(rd, 32'h0);
    wb(1'b0, IDX_FN_LO, 2'b11, 16'h0);
    cmp_reg(rd, 32'h0);
    wb(1'b0, IDX_DIR, 2'b01, 16'h0);
    cmp_reg(rd, 32'h0);
    cmp_pin({pad_o.oe, pad_o.out & pad_o.oe, pad_o.pull_up, pad_o.pull_down, adc_sel_o, pwm_sel_o}, '0);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- hdl/spp_pkg.sv ----
// shared constants and types for the six pin port configuration block
// assumes a 32-bit classic wishbone master and one 100 MHz system clock
`default_nettype none

package spp_pkg;

  // geometry of the port
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned PWM_PIN   = 4;
  localparam int unsigned ADR_W     = 18;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_DATA   = 16'hf218;
  localparam logic [15:0] IDX_DIR    = 16'hf219;
  localparam logic [15:0] IDX_DRV_LO = 16'hf21a;
  localparam logic [15:0] IDX_DRV_HI = 16'hf21b;
  localparam logic [15:0] IDX_FN_LO  = 16'hf21c;
  localparam logic [15:0] IDX_FN_HI  = 16'hf21d;

  // reset values
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_DRV_LO = 8'h00;
  localparam logic [7:0] RST_DRV_HI = 8'h00;
  localparam logic [7:0] RST_FN_LO  = 8'h00;
  localparam logic [7:0] RST_FN_HI  = 8'h00;

  // direction bit meaning
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN  = 1'b1;

  // drive selector, output mode reading
  typedef enum logic [1:0] {
    DRV_HIZ  = 2'b00,
    DRV_PCH  = 2'b01,
    DRV_NCH  = 2'b10,
    DRV_CMOS = 2'b11
  } spp_drive_type;

  // drive selector, input mode reading
  localparam logic [1:0] IN_PULL_DOWN = 2'b01;
  localparam logic [1:0] IN_PULL_UP   = 2'b10;

  // function selector
  typedef enum logic [1:0] {
    FN_GPIO = 2'b00,
    FN_ADC  = 2'b01,
    FN_PWM  = 2'b10,
    FN_BAD  = 2'b11
  } spp_func_type;

  // wishbone request from the master
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } spp_wb_req_type;

  // wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } spp_wb_rsp_type;

  // pad controls, one bit per pin
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
    logic [PIN_COUNT-1:0] pull_up;
    logic [PIN_COUNT-1:0] pull_down;
  } spp_pad_type;

  // whole block state
  typedef struct packed {
    logic [7:0]           data;
    logic [7:0]           dir;
    logic [7:0]           drv_lo;
    logic [7:0]           drv_hi;
    logic [7:0]           fn_lo;
    logic [7:0]           fn_hi;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    spp_pad_type          pad;
    logic [PIN_COUNT-1:0] adc_sel;
    logic                 pwm_sel;
    logic                 ack;
    logic [31:0]          rdat;
  } spp_state_type;

  localparam spp_state_type STATE_RESET = '{
    data:    RST_DATA,
    dir:     RST_DIR,
    drv_lo:  RST_DRV_LO,
    drv_hi:  RST_DRV_HI,
    fn_lo:   RST_FN_LO,
    fn_hi:   RST_FN_HI,
    default: '0
  };

endpackage

`default_nettype wire

// ---- hdl/spp_port.sv ----
// six pin port configuration: direction, drive style, pulls and pin function
// assumes a classic wishbone master on clk_i and pads that resolve oe/out/pulls
//
// Register access over Wishbone is this design's own decision.
`default_nettype none

module spp_port (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire spp_pkg::spp_wb_req_type       wb_req_i,
  output var  spp_pkg::spp_wb_rsp_type       wb_rsp_o,
  input  wire logic [spp_pkg::PIN_COUNT-1:0] pad_in_i,
  input  wire logic                          pwm_i,
  output var  spp_pkg::spp_pad_type          pad_o,
  output var  logic [spp_pkg::PIN_COUNT-1:0] adc_sel_o,
  output var  logic                          pwm_sel_o
);
  import spp_pkg::*;

  spp_state_type st_q;     // registered state
  spp_state_type st_d;     // next state
  logic [15:0]   idx;      // word index of the request
  logic          req;      // live request this cycle
  logic          wr_now;   // write takes effect this edge
  logic [1:0]    dsel;     // drive selector of one pin
  logic [1:0]    fsel;     // function selector of one pin
  logic          fn_bad;   // forbidden code on one pin
  logic          level;    // level wanted on one pin
  logic [7:0]    rd_data;  // data register as read

  // request decode
  assign idx    = wb_req_i.adr[ADR_W-1:2];
  assign req    = wb_req_i.cyc & wb_req_i.stb;
  assign wr_now = req & st_q.ack & wb_req_i.we;

  // data register view: pins for inputs, stored bits otherwise
  always_comb begin
    rd_data = st_q.data;
    for (int n = 0; n < PIN_COUNT; n++) begin
      if (st_q.dir[n] == DIR_IN) begin
        rd_data[n] = st_q.sync2[n];
      end
    end
  end

  // next state: bus slave, synchroniser and pad decode
  always_comb begin
    st_d = st_q;
    dsel = 2'b00;
    fsel = 2'b00;
    fn_bad = 1'b0;
    level = 1'b0;

    // pins come from the board, two flops before any use
    st_d.sync1 = pad_in_i;
    st_d.sync2 = st_q.sync1;

    // one wait state: ack rises the cycle after the request, drops after
    st_d.ack = req & ~st_q.ack;

    // read data captured as ack is raised; unmapped reads give zero
    if (req & ~st_q.ack) begin
      st_d.rdat = 32'h0000_0000;
      unique case (idx)
        IDX_DATA: begin
          st_d.rdat[7:0] = rd_data;
        end
        IDX_DIR: begin
          st_d.rdat[7:0] = st_q.dir;
        end
        IDX_DRV_LO: begin
          // word view of the pair: low register in lane 0, high in lane 1
          st_d.rdat[15:0] = {st_q.drv_hi, st_q.drv_lo};
        end
        IDX_DRV_HI: begin
          st_d.rdat[7:0] = st_q.drv_hi;
        end
        IDX_FN_LO: begin
          st_d.rdat[15:0] = {st_q.fn_hi, st_q.fn_lo};
        end
        IDX_FN_HI: begin
          st_d.rdat[7:0] = st_q.fn_hi;
        end
        default: begin
          st_d.rdat = 32'h0000_0000;
        end
      endcase
    end

    // writes land at the edge where the master sees ack
    if (wr_now) begin
      unique case (idx)
        IDX_DATA: begin
          if (wb_req_i.sel[0]) begin
            st_d.data = wb_req_i.dat[7:0];
          end
        end
        IDX_DIR: begin
          if (wb_req_i.sel[0]) begin
            st_d.dir = wb_req_i.dat[7:0];
          end
        end
        IDX_DRV_LO: begin
          // byte or halfword; lane 1 reaches the partner register
          if (wb_req_i.sel[0]) begin
            st_d.drv_lo = wb_req_i.dat[7:0];
          end
          if (wb_req_i.sel[1]) begin
            st_d.drv_hi = wb_req_i.dat[15:8];
          end
        end
        IDX_DRV_HI: begin
          if (wb_req_i.sel[0]) begin
            st_d.drv_hi = wb_req_i.dat[7:0];
          end
        end
        IDX_FN_LO: begin
          if (wb_req_i.sel[0]) begin
            st_d.fn_lo = wb_req_i.dat[7:0];
          end
          if (wb_req_i.sel[1]) begin
            st_d.fn_hi = wb_req_i.dat[15:8];
          end
        end
        IDX_FN_HI: begin
          if (wb_req_i.sel[0]) begin
            st_d.fn_hi = wb_req_i.dat[7:0];
          end
        end
        default: begin
          // unmapped write is acknowledged and dropped
          st_d.data = st_q.data;
        end
      endcase
    end

    // per pin decode, registered so the pads never see glitches
    // note: decode uses current registers, so a write shows one cycle later
    for (int n = 0; n < PIN_COUNT; n++) begin
      dsel = {st_q.drv_hi[n], st_q.drv_lo[n]};
      fsel = {st_q.fn_hi[n], st_q.fn_lo[n]};

      // legal codes: 00 on all, 01 on all, 10 only on the pwm pin
      fn_bad = (fsel == FN_BAD) ||
               ((fsel == FN_PWM) && (n != PWM_PIN));

      // converter owns the pin on code 01 for every pin
      st_d.adc_sel[n] = (fsel == FN_ADC);

      // level source: data register, pwm, or forced low when forbidden
      if (fn_bad) begin
        level = 1'b0;
      end else if ((fsel == FN_PWM) && (n == PWM_PIN)) begin
        level = pwm_i;
      end else begin
        level = st_q.data[n];
      end

      // defaults: released, no pulls
      st_d.pad.out[n]       = 1'b0;
      st_d.pad.oe[n]        = 1'b0;
      st_d.pad.pull_up[n]   = 1'b0;
      st_d.pad.pull_down[n] = 1'b0;

      if (st_q.dir[n] == DIR_OUT) begin
        if (fsel != FN_ADC) begin
          // converter function leaves the pad to the converter
          unique case (spp_drive_type'(dsel))
            DRV_HIZ: begin
              st_d.pad.oe[n] = 1'b0;
            end
            DRV_PCH: begin
              // only sources high; a low level floats the pin
              st_d.pad.out[n] = 1'b1;
              st_d.pad.oe[n]  = level;
            end
            DRV_NCH: begin
              // only sinks low; a high level floats the pin
              st_d.pad.out[n] = 1'b0;
              st_d.pad.oe[n]  = ~level;
            end
            DRV_CMOS: begin
              st_d.pad.out[n] = level;
              st_d.pad.oe[n]  = 1'b1;
            end
          endcase
        end
      end else begin
        // input mode: pad never driven, selector picks a pull
        // pulls stay as chosen even under the converter; software must
        // pick plain input there or the pull draws current
        st_d.pad.pull_down[n] = (dsel == IN_PULL_DOWN);
        st_d.pad.pull_up[n]   = (dsel == IN_PULL_UP);
      end
    end

    // pwm routed only on its own pin with its own code
    st_d.pwm_sel = ({st_q.fn_hi[PWM_PIN], st_q.fn_lo[PWM_PIN]} == FN_PWM);
  end

  // state register, synchronous reset to documented values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = st_q.rdat;
  assign pad_o        = st_q.pad;
  assign adc_sel_o    = st_q.adc_sel;
  assign pwm_sel_o    = st_q.pwm_sel;

endmodule

`default_nettype wire
